// [rtl/resolver_pkg.sv]
// shared constants, codes and helpers for the resolver converter link
// What this block does
// R1 - parallel read drives bit 13 when selected
// R2 - serial mode: bit 13 is host clock
// R3 - bits 12..8 driven only during read
// R4 - low byte: read out, write in
// R5 - quadrature pair runs free when valid
// R6 - north marker runs free when valid
// R7 - direction high while angle increases
// R8 - host holds reset low until ready
// R9 - tracking loss low, follows present state
// R10 - degradation low on overrange or mismatch
// R11 - two pins pick operating mode
// R12 - two pins pick resolution
// R13 - excitation rate set by frequency register
// R14 - select pin low serial, high parallel
// R15 - sample falling edge latches position, velocity, faults
// R16 - quadrature order follows rotation direction
package resolver_pkg;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int PHASE_W = 20;
    // my own register addresses in configuration mode
    localparam logic [6:0] ADDR_EXC_FREQ = 7'h11;
    localparam logic [6:0] ADDR_FAULT = 7'h7F;
    localparam logic [7:0] EXC_FREQ_RESET = 8'h28;
    localparam int ADDR_FLAG_BIT = 7;
    // mode select codes
    localparam logic [1:0] MODE_POSITION = 2'h0;
    localparam logic [1:0] MODE_VELOCITY = 2'h2;
    localparam logic [1:0] MODE_CONFIG = 2'h3;
    // fault register bits
    localparam int FAULT_LOT_BIT = 0;
    localparam int FAULT_DOS_BIT = 1;
    localparam int FAULT_MISMATCH_BIT = 2;
    localparam int FAULT_INVALID_BIT = 3;
    // pin bits in the bus
    localparam int SCLK_BIT = 13;
    localparam int SDI_BIT = 14;
    localparam int SDO_BIT = 15;
    // synchronised pin vector layout
    localparam int SY_CS_N = 25;
    localparam int SY_RD_N = 24;
    localparam int SY_WR_N = 23;
    localparam int SY_PAR_SEL = 22;
    localparam int SY_SAMPLE_N = 21;
    localparam int SY_RESET_N = 20;
    localparam int SY_MODE_HI = 19;
    localparam int SY_MODE_LO = 18;
    localparam int SY_RES_HI = 17;
    localparam int SY_RES_LO = 16;
    localparam int SY_W = 26;
    // timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int STROBE_HOLD_NS = 40;
    localparam int STROBE_HOLD_CYC = (STROBE_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SCLK_HALF_NS = 32;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RESET_HOLD_NS = 400;
    localparam int RESET_HOLD_CYC = (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SER_BITS = 16;

    typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_SERIAL, OP_SAMPLE} op_t;

    // keep only the bits the chosen resolution resolves
    function automatic logic [15:0] res_mask(input logic [1:0] code);
        unique case (code)
            2'h0: res_mask = 16'hFFC0;
            2'h1: res_mask = 16'hFFF0;
            2'h2: res_mask = 16'hFFFC;
            default: res_mask = 16'hFFFF;
        endcase
    endfunction

    // position of the least resolved bit
    function automatic logic [3:0] res_lsb(input logic [1:0] code);
        unique case (code)
            2'h0: res_lsb = 4'h6;
            2'h1: res_lsb = 4'h4;
            2'h2: res_lsb = 4'h2;
            default: res_lsb = 4'h0;
        endcase
    endfunction
endpackage

// [rtl/resolver_link_if.sv]
// pin-level link between the converter and its host
`timescale 1ns/100ps
interface resolver_link_if;
    logic csN;
    logic rdN;
    logic wrFsyncN;
    logic serialPortSelect;
    logic sampleN;
    logic resetN;
    logic modeSelHi;
    logic modeSelLo;
    logic resolutionSelHi;
    logic resolutionSelLo;
    logic [15:0] devDataOut;
    logic [15:0] devDataOe;
    logic [15:0] hostDataOut;
    logic [15:0] hostDataOe;
    logic [15:0] busLevel;
    logic encA;
    logic encB;
    logic northMarker;
    logic direction;
    logic trackingLossN;
    logic signalDegradeN;
    logic excitationOut;
    logic excitationOutN;

    // undriven pins float high as with a weak pull-up
    assign busLevel = (devDataOe & devDataOut) | (~devDataOe & hostDataOe & hostDataOut)
        | (~devDataOe & ~hostDataOe);

    modport device (
        input csN, rdN, wrFsyncN, serialPortSelect, sampleN, resetN,
        input modeSelHi, modeSelLo, resolutionSelHi, resolutionSelLo, busLevel,
        output devDataOut, devDataOe, encA, encB, northMarker, direction,
        output trackingLossN, signalDegradeN, excitationOut, excitationOutN
    );
    modport host (
        output csN, rdN, wrFsyncN, serialPortSelect, sampleN, resetN,
        output modeSelHi, modeSelLo, resolutionSelHi, resolutionSelLo,
        output hostDataOut, hostDataOe,
        input busLevel, encA, encB, northMarker, direction,
        input trackingLossN, signalDegradeN, excitationOut, excitationOutN
    );
endinterface

// [rtl/resolver_device_end.sv]
// converter end: data port, encoder emulation, fault pins, excitation
`timescale 1ns/100ps
module resolver_device_end
    import resolver_pkg::*;
(
    input wire logic mclk, // 250 MHz clock
    input wire logic rstn, // async reset, active low
    resolver_link_if.device link, // pins toward the host
    input wire logic [15:0] angleIn, // tracking loop angle
    input wire logic [15:0] velocityIn, // tracking loop velocity
    input wire logic signalsValid, // resolver inputs valid
    input wire logic trackLost, // tracking lost now
    input wire logic amplitudeHigh, // amplitude above threshold
    input wire logic amplitudeMismatch, // sine/cosine mismatch
    output logic [1:0] resolutionCode, // decoded resolution
    output logic [7:0] excFreqCode // excitation register
);
    // ****************
    // pin synchronisers
    // ****************
    logic [SY_W-1:0] pinsRaw;
    logic [SY_W-1:0] meta_r;
    logic [SY_W-1:0] pins_r;
    logic [SY_W-1:0] prev_r;

    assign pinsRaw = {link.csN, link.rdN, link.wrFsyncN, link.serialPortSelect, link.sampleN,
        link.resetN, link.modeSelHi, link.modeSelLo, link.resolutionSelHi,
        link.resolutionSelLo, link.busLevel};

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_r <= '1;
            pins_r <= '1;
            prev_r <= '1;
        end
        else
        begin
            meta_r <= pinsRaw;
            pins_r <= meta_r;
            prev_r <= pins_r;
        end
    end

    // ****************
    // core state
    // ****************
    logic [15:0] posReg_r, posReg_nxt;
    logic [15:0] velReg_r, velReg_nxt;
    logic [7:0] fault_r, fault_nxt;
    logic [6:0] addr_r, addr_nxt;
    logic [7:0] excFreq_r, excFreq_nxt;
    logic [15:0] shiftOut_r, shiftOut_nxt;
    logic [7:0] shiftIn_r, shiftIn_nxt;
    logic [15:0] dataOut_r, dataOut_nxt;
    logic [15:0] dataOe_r, dataOe_nxt;
    logic [15:0] prevAngle_r, prevAngle_nxt;
    logic encA_r, encA_nxt;
    logic encB_r, encB_nxt;
    logic nm_r, nm_nxt;
    logic dir_r, dir_nxt;
    logic lotN_r, lotN_nxt;
    logic dosN_r, dosN_nxt;
    logic [PHASE_W-1:0] phase_r, phase_nxt;
    logic excP_r, excP_nxt;
    logic [1:0] res_r, res_nxt;

    logic csOn, rdOn, wrOn, parSel, linkRst;
    logic wrRise, wrFall, sampleFall, sclkRise, sclkFall;
    logic [1:0] mode, resPins;
    logic [15:0] mask, word, angleM, diff;
    logic [3:0] lsb;
    logic wrTake;
    logic [7:0] wrByte;

    assign csOn = !pins_r[SY_CS_N];
    assign rdOn = !pins_r[SY_RD_N];
    assign wrOn = !pins_r[SY_WR_N];
    // R14 select decode
    assign parSel = pins_r[SY_PAR_SEL];
    assign linkRst = !pins_r[SY_RESET_N];
    // R11 mode decode
    assign mode = {pins_r[SY_MODE_HI], pins_r[SY_MODE_LO]};
    // R12 resolution decode
    assign resPins = {pins_r[SY_RES_HI], pins_r[SY_RES_LO]};
    assign wrRise = pins_r[SY_WR_N] && !prev_r[SY_WR_N];
    assign wrFall = !pins_r[SY_WR_N] && prev_r[SY_WR_N];
    assign sampleFall = !pins_r[SY_SAMPLE_N] && prev_r[SY_SAMPLE_N];
    // R2 serial clock edges
    assign sclkRise = !parSel && pins_r[SCLK_BIT] && !prev_r[SCLK_BIT];
    assign sclkFall = !parSel && !pins_r[SCLK_BIT] && prev_r[SCLK_BIT];

    always_comb
    begin
        posReg_nxt = posReg_r;
        velReg_nxt = velReg_r;
        fault_nxt = fault_r;
        addr_nxt = addr_r;
        excFreq_nxt = excFreq_r;
        shiftOut_nxt = shiftOut_r;
        shiftIn_nxt = shiftIn_r;
        dataOut_nxt = dataOut_r;
        dataOe_nxt = 16'h0000;
        prevAngle_nxt = prevAngle_r;
        encA_nxt = encA_r;
        encB_nxt = encB_r;
        nm_nxt = nm_r;
        dir_nxt = dir_r;
        res_nxt = resPins;
        mask = res_mask(res_r);
        lsb = res_lsb(res_r);

        unique case (mode)
            MODE_CONFIG: word = (addr_r == ADDR_FAULT) ? {8'h00, fault_r} : {8'h00, excFreq_r};
            MODE_VELOCITY: word = velReg_r & mask;
            default: word = posReg_r & mask;
        endcase

        // R15 sample latch
        if (sampleFall)
        begin
            posReg_nxt = angleIn;
            velReg_nxt = velocityIn;
            fault_nxt = 8'h00;
            fault_nxt[FAULT_LOT_BIT] = trackLost;
            fault_nxt[FAULT_DOS_BIT] = amplitudeHigh;
            fault_nxt[FAULT_MISMATCH_BIT] = amplitudeMismatch;
            fault_nxt[FAULT_INVALID_BIT] = !signalsValid;
        end

        // R1 R3 R4 parallel read enable
        if (parSel && csOn && rdOn)
        begin
            dataOe_nxt = 16'hFFFF;
            dataOut_nxt = word;
        end

        // serial frame: load on frame start, shift out on rising clock
        if (!parSel && csOn && wrFall)
        begin
            shiftOut_nxt = word;
        end
        if (!parSel && csOn && wrOn)
        begin
            dataOe_nxt[SDO_BIT] = 1'b1;
            if (sclkRise)
            begin
                dataOut_nxt[SDO_BIT] = shiftOut_r[DATA_W-1];
                shiftOut_nxt = {shiftOut_r[DATA_W-2:0], 1'b0};
            end
            if (sclkFall)
            begin
                shiftIn_nxt = {shiftIn_r[BYTE_W-2:0], pins_r[SDI_BIT]};
            end
        end

        // R4 byte taken on the write strobe's rising edge
        wrTake = wrRise && !prev_r[SY_CS_N] && (mode == MODE_CONFIG);
        wrByte = parSel ? pins_r[BYTE_W-1:0] : shiftIn_r;
        if (wrTake)
        begin
            if (wrByte[ADDR_FLAG_BIT])
            begin
                addr_nxt = wrByte[6:0];
            end
            else if (addr_r == ADDR_EXC_FREQ)
            begin
                excFreq_nxt = wrByte;
            end
        end

        // R5 R6 outputs frozen while inputs invalid
        angleM = angleIn & mask;
        diff = angleM - prevAngle_r;
        if (signalsValid)
        begin
            prevAngle_nxt = angleM;
            // R16 gray pair reverses with direction
            encA_nxt = angleM[lsb + 4'h1];
            encB_nxt = angleM[lsb + 4'h1] ^ angleM[lsb];
            nm_nxt = (angleM & ~(16'h0003 << lsb)) == 16'h0000;
            // R7 direction from signed step
            if (diff != 16'h0000)
            begin
                dir_nxt = !diff[DATA_W-1];
            end
        end

        // R9 live tracking flag
        lotN_nxt = !trackLost;
        // R10 degradation flag
        dosN_nxt = !(amplitudeHigh || amplitudeMismatch);
        // R13 phase accumulator
        phase_nxt = phase_r + {{(PHASE_W-8){1'b0}}, excFreq_r};
        excP_nxt = phase_r[PHASE_W-1];

        // R8 pin reset rebuilds control state
        if (linkRst)
        begin
            addr_nxt = 7'h00;
            excFreq_nxt = EXC_FREQ_RESET;
            fault_nxt = 8'h00;
            dataOe_nxt = 16'h0000;
            phase_nxt = '0;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            posReg_r <= 16'h0000;
            velReg_r <= 16'h0000;
            fault_r <= 8'h00;
            addr_r <= 7'h00;
            excFreq_r <= EXC_FREQ_RESET;
            shiftOut_r <= 16'h0000;
            shiftIn_r <= 8'h00;
            dataOut_r <= 16'h0000;
            dataOe_r <= 16'h0000;
            prevAngle_r <= 16'h0000;
            encA_r <= 1'b0;
            encB_r <= 1'b0;
            nm_r <= 1'b0;
            dir_r <= 1'b1;
            lotN_r <= 1'b1;
            dosN_r <= 1'b1;
            phase_r <= '0;
            excP_r <= 1'b0;
            res_r <= 2'h3;
        end
        else
        begin
            posReg_r <= posReg_nxt;
            velReg_r <= velReg_nxt;
            fault_r <= fault_nxt;
            addr_r <= addr_nxt;
            excFreq_r <= excFreq_nxt;
            shiftOut_r <= shiftOut_nxt;
            shiftIn_r <= shiftIn_nxt;
            dataOut_r <= dataOut_nxt;
            dataOe_r <= dataOe_nxt;
            prevAngle_r <= prevAngle_nxt;
            encA_r <= encA_nxt;
            encB_r <= encB_nxt;
            nm_r <= nm_nxt;
            dir_r <= dir_nxt;
            lotN_r <= lotN_nxt;
            dosN_r <= dosN_nxt;
            phase_r <= phase_nxt;
            excP_r <= excP_nxt;
            res_r <= res_nxt;
        end
    end

    assign link.devDataOut = dataOut_r;
    assign link.devDataOe = dataOe_r;
    assign link.encA = encA_r;
    assign link.encB = encB_r;
    assign link.northMarker = nm_r;
    assign link.direction = dir_r;
    assign link.trackingLossN = lotN_r;
    assign link.signalDegradeN = dosN_r;
    assign link.excitationOut = excP_r;
    assign link.excitationOutN = !excP_r;
    assign resolutionCode = res_r;
    assign excFreqCode = excFreq_r;
endmodule

// [rtl/resolver_host_end.sv]
// host end: drives strobes, selects, reset and serial clock
`timescale 1ns/100ps
module resolver_host_end
    import resolver_pkg::*;
(
    input wire logic mclk, // 250 MHz clock
    input wire logic rstn, // async reset, active low
    resolver_link_if.host link, // pins toward the converter
    input wire logic opStart, // one-cycle request
    input wire op_t opKind, // kind of request
    input wire logic [7:0] opByte, // byte to write
    input wire logic useSerial, // serial port wanted
    input wire logic [1:0] modeCode, // mode pins value
    input wire logic [1:0] resCode, // resolution pins value
    output logic opBusy, // request in progress
    output logic rspValid, // one-cycle read result
    output logic [15:0] rspData // read result
);
    typedef enum {ST_RESET, ST_IDLE, ST_STROBE, ST_GAP, ST_SER_HI, ST_SER_LO} state_t;

    logic [15:0] busMeta_r, busSync_r;
    state_t state_r, state_nxt;
    op_t op_r, op_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [4:0] bitCnt_r, bitCnt_nxt;
    logic [15:0] txWord_r, txWord_nxt;
    logic [15:0] rx_r, rx_nxt;
    logic csN_r, csN_nxt, rdN_r, rdN_nxt, wrN_r, wrN_nxt, parSel_r, parSel_nxt;
    logic sampleN_r, sampleN_nxt, resetN_r, resetN_nxt;
    logic [1:0] mode_r, mode_nxt, res_r, res_nxt;
    logic [15:0] dOut_r, dOut_nxt, dOe_r, dOe_nxt;
    logic busy_r, busy_nxt, rspV_r, rspV_nxt;

    // bus comes back through two flops before use
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            busMeta_r <= 16'hFFFF;
            busSync_r <= 16'hFFFF;
        end
        else
        begin
            busMeta_r <= link.busLevel;
            busSync_r <= busMeta_r;
        end
    end

    always_comb
    begin
        state_nxt = state_r;
        op_nxt = op_r;
        cnt_nxt = cnt_r + 8'h01;
        bitCnt_nxt = bitCnt_r;
        txWord_nxt = txWord_r;
        rx_nxt = rx_r;
        csN_nxt = csN_r;
        rdN_nxt = rdN_r;
        wrN_nxt = wrN_r;
        parSel_nxt = parSel_r;
        sampleN_nxt = sampleN_r;
        resetN_nxt = resetN_r;
        mode_nxt = mode_r;
        res_nxt = res_r;
        dOut_nxt = dOut_r;
        dOe_nxt = dOe_r;
        busy_nxt = 1'b1;
        rspV_nxt = 1'b0;
        unique case (state_r)
            // R8 hold converter in reset
            ST_RESET:
            begin
                if (cnt_r == 8'(RESET_HOLD_CYC - 1))
                begin
                    resetN_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                    busy_nxt = 1'b0;
                end
            end
            ST_IDLE:
            begin
                busy_nxt = 1'b0;
                // R11 R12 R14 select pins move only between requests
                parSel_nxt = !useSerial;
                mode_nxt = modeCode;
                res_nxt = resCode;
                // R2 host owns bit 13 in serial mode
                dOe_nxt = useSerial ? 16'h2000 : 16'h0000;
                dOut_nxt = 16'h0000;
                cnt_nxt = 8'h00;
                if (opStart)
                begin
                    busy_nxt = 1'b1;
                    op_nxt = opKind;
                    state_nxt = ST_STROBE;
                    unique case (opKind)
                        OP_READ:
                        begin
                            csN_nxt = 1'b0;
                            rdN_nxt = 1'b0;
                        end
                        OP_WRITE:
                        begin
                            csN_nxt = 1'b0;
                            wrN_nxt = 1'b0;
                            dOe_nxt = 16'h00FF;
                            dOut_nxt = {8'h00, opByte};
                        end
                        OP_SERIAL:
                        begin
                            csN_nxt = 1'b0;
                            wrN_nxt = 1'b0;
                            txWord_nxt = {8'h00, opByte};
                            bitCnt_nxt = 5'h00;
                        end
                        OP_SAMPLE: sampleN_nxt = 1'b0;
                    endcase
                end
            end
            ST_STROBE:
            begin
                if (cnt_r == 8'(STROBE_HOLD_CYC - 1))
                begin
                    cnt_nxt = 8'h00;
                    if (op_r == OP_SERIAL)
                    begin
                        state_nxt = ST_SER_HI;
                        dOe_nxt = 16'h6000;
                        dOut_nxt = 16'h2000 | ({15'h0000, txWord_r[DATA_W-1]} << SDI_BIT);
                        txWord_nxt = {txWord_r[DATA_W-2:0], 1'b0};
                    end
                    else
                    begin
                        if (op_r == OP_READ)
                        begin
                            rx_nxt = busSync_r;
                            rspV_nxt = 1'b1;
                        end
                        state_nxt = ST_GAP;
                        csN_nxt = 1'b1;
                        rdN_nxt = 1'b1;
                        wrN_nxt = 1'b1;
                        sampleN_nxt = 1'b1;
                    end
                end
            end
            // R2 one serial clock period per bit
            ST_SER_HI:
            begin
                if (cnt_r == 8'(SCLK_HALF_CYC - 1))
                begin
                    cnt_nxt = 8'h00;
                    dOut_nxt[SCLK_BIT] = 1'b0;
                    state_nxt = ST_SER_LO;
                end
            end
            ST_SER_LO:
            begin
                if (cnt_r == 8'(SCLK_HALF_CYC - 1))
                begin
                    cnt_nxt = 8'h00;
                    rx_nxt = {rx_r[DATA_W-2:0], busSync_r[SDO_BIT]};
                    bitCnt_nxt = bitCnt_r + 5'h01;
                    if (bitCnt_r == 5'(SER_BITS - 1))
                    begin
                        rspV_nxt = 1'b1;
                        csN_nxt = 1'b1;
                        wrN_nxt = 1'b1;
                        dOe_nxt = 16'h2000;
                        state_nxt = ST_GAP;
                    end
                    else
                    begin
                        dOut_nxt[SCLK_BIT] = 1'b1;
                        dOut_nxt[SDI_BIT] = txWord_r[DATA_W-1];
                        txWord_nxt = {txWord_r[DATA_W-2:0], 1'b0};
                        state_nxt = ST_SER_HI;
                    end
                end
            end
            ST_GAP:
            begin
                if (cnt_r == 8'(STROBE_HOLD_CYC - 1))
                begin
                    dOe_nxt = parSel_r ? 16'h0000 : 16'h2000;
                    state_nxt = ST_IDLE;
                    busy_nxt = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= ST_RESET;
            op_r <= OP_READ;
            cnt_r <= 8'h00;
            bitCnt_r <= 5'h00;
            txWord_r <= 16'h0000;
            rx_r <= 16'h0000;
            csN_r <= 1'b1;
            rdN_r <= 1'b1;
            wrN_r <= 1'b1;
            parSel_r <= 1'b1;
            sampleN_r <= 1'b1;
            resetN_r <= 1'b0;
            mode_r <= 2'h0;
            res_r <= 2'h3;
            dOut_r <= 16'h0000;
            dOe_r <= 16'h0000;
            busy_r <= 1'b1;
            rspV_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            cnt_r <= cnt_nxt;
            bitCnt_r <= bitCnt_nxt;
            txWord_r <= txWord_nxt;
            rx_r <= rx_nxt;
            csN_r <= csN_nxt;
            rdN_r <= rdN_nxt;
            wrN_r <= wrN_nxt;
            parSel_r <= parSel_nxt;
            sampleN_r <= sampleN_nxt;
            resetN_r <= resetN_nxt;
            mode_r <= mode_nxt;
            res_r <= res_nxt;
            dOut_r <= dOut_nxt;
            dOe_r <= dOe_nxt;
            busy_r <= busy_nxt;
            rspV_r <= rspV_nxt;
        end
    end

    assign link.csN = csN_r;
    assign link.rdN = rdN_r;
    assign link.wrFsyncN = wrN_r;
    assign link.serialPortSelect = parSel_r;
    assign link.sampleN = sampleN_r;
    assign link.resetN = resetN_r;
    assign link.modeSelHi = mode_r[1];
    assign link.modeSelLo = mode_r[0];
    assign link.resolutionSelHi = res_r[1];
    assign link.resolutionSelLo = res_r[0];
    assign link.hostDataOut = dOut_r;
    assign link.hostDataOe = dOe_r;
    assign opBusy = busy_r;
    assign rspValid = rspV_r;
    assign rspData = rx_r;
endmodule

// [verification/resolver_link_asserts.sv]
// concurrent checks on the converter link pins
`timescale 1ns/100ps
module resolver_link_asserts (
    input wire logic mclk, // clock
    input wire logic rstn, // reset
    input wire logic resetN, // converter reset
    input wire logic csN, // select
    input wire logic rdN, // read strobe
    input wire logic wrFsyncN, // write strobe
    input wire logic serialPortSelect, // 1 parallel
    input wire logic [15:0] devDataOe, // device drive
    input wire logic encA, // quadrature a
    input wire logic encB, // quadrature b
    input wire logic direction, // rotation sense
    input wire logic excitationOut, // excitation
    input wire logic excitationOutN // excitation inverse
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    // long enough for the two-flop sync plus the answer latency
    sequence s_rd; (!csN && !rdN && serialPortSelect) [*8]; endsequence
    sequence s_wr; (!csN && !wrFsyncN) [*6]; endsequence
    sequence s_ser; (!csN && !wrFsyncN && !serialPortSelect) [*8]; endsequence
    property p_rd; s_rd |-> devDataOe == 16'hFFFF; endproperty
    a_rd: assert property (p_rd) else $error("read drive");
    property p_wr; s_wr |-> devDataOe[7:0] == 8'h00; endproperty
    a_wr: assert property (p_wr) else $error("low byte driven in write");
    property p_ser; !serialPortSelect |-> devDataOe[14:0] == 15'h0000; endproperty
    a_ser: assert property (p_ser) else $error("serial drive");
    property p_sdo; s_ser |-> devDataOe[15]; endproperty
    a_sdo: assert property (p_sdo) else $error("serial out");
    property p_quad; !($changed(encA) && $changed(encB)); endproperty
    a_quad: assert property (p_quad) else $error("quadrature");
    property p_dir; $changed(encB) |-> direction == $past(encA == encB); endproperty
    a_dir: assert property (p_dir) else $error("direction");
    property p_rst; $rose(rstn) |-> !resetN [*8]; endproperty
    a_rst: assert property (p_rst) else $error("reset hold");
    property p_exc; excitationOutN == !excitationOut; endproperty
    a_exc: assert property (p_exc) else $error("excitation pair");
endmodule

// [verification/testbench.sv]
// self-checking bench joining the host end to the converter end
`timescale 1ns/100ps
module testbench
    import resolver_pkg::*;
;
    logic mclk = 0, rstn = 0, opStart = 0, useSerial = 0, signalsValid = 1, a, rspValid;
    logic trackLost = 0, amplitudeHigh = 0, amplitudeMismatch = 0, opBusy;
    logic [1:0] modeCode = MODE_POSITION, resCode = 2'h3, resolutionCode;
    logic [7:0] opByte = 8'h00, excFreqCode;
    logic [15:0] angleIn = 16'h1234, velocityIn = 16'hABCD, rspData, nRsp = 16'h0000;
    op_t opKind = OP_READ;
    int n_fail = 0, num_checks = 0;
    resolver_link_if link ();
    resolver_device_end u_resolver_device_end (.mclk, .rstn, .link, .angleIn, .velocityIn,
        .signalsValid, .trackLost, .amplitudeHigh, .amplitudeMismatch, .resolutionCode,
        .excFreqCode);
    resolver_host_end u_resolver_host_end (.mclk, .rstn, .link, .opStart, .opKind, .opByte,
        .useSerial, .modeCode, .resCode, .opBusy, .rspValid, .rspData);
    resolver_link_asserts u_resolver_link_asserts (.mclk, .rstn, .resetN(link.resetN),
        .csN(link.csN), .rdN(link.rdN), .wrFsyncN(link.wrFsyncN),
        .serialPortSelect(link.serialPortSelect), .devDataOe(link.devDataOe),
        .encA(link.encA), .encB(link.encB), .direction(link.direction),
        .excitationOut(link.excitationOut), .excitationOutN(link.excitationOutN));
    always #2 mclk = ~mclk;
    always @(negedge mclk) if (rspValid === 1'b1) nRsp++;
    task automatic op(input op_t k, input logic [7:0] b);
        opKind = k;
        opByte = b;
        opStart = 1;
        @(negedge mclk);
        opStart = 0;
        repeat (1000) if (opBusy !== 1'b0) @(negedge mclk);
    endtask
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic step(input logic [15:0] d);
        repeat (3)
        begin
            angleIn = angleIn + d;
            repeat (4) @(negedge mclk);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(negedge mclk);
        rstn = 1;
        repeat (200) if (opBusy !== 1'b0) @(negedge mclk);
        op(OP_SAMPLE, 8'h00);
        op(OP_READ, 8'h00);
        chk("pos16", 16'h1234, rspData);
        resCode = 2'h0;
        op(OP_SAMPLE, 8'h00);
        op(OP_READ, 8'h00);
        chk("pos10", 16'h1200, rspData);
        chk("rescode", 16'h0000, resolutionCode);
        resCode = 2'h3;
        modeCode = MODE_VELOCITY;
        op(OP_SAMPLE, 8'h00);
        op(OP_READ, 8'h00);
        chk("vel", 16'hABCD, rspData);
        modeCode = MODE_CONFIG;
        op(OP_WRITE, {1'b1, ADDR_EXC_FREQ});
        op(OP_WRITE, 8'h3C);
        op(OP_READ, 8'h00);
        chk("excreg", 16'h003C, rspData);
        chk("excfreq", 16'h003C, excFreqCode);
        op(OP_WRITE, {1'b1, ADDR_FAULT});
        trackLost = 1;
        amplitudeMismatch = 1;
        op(OP_SAMPLE, 8'h00);
        op(OP_READ, 8'h00);
        chk("fault", 16'h0005, rspData);
        chk("pinslo", 16'h0000, {link.trackingLossN, link.signalDegradeN});
        trackLost = 0;
        amplitudeMismatch = 0;
        repeat (4) @(negedge mclk);
        chk("pinshi", 16'h0003, {link.trackingLossN, link.signalDegradeN});
        modeCode = MODE_POSITION;
        useSerial = 1;
        op(OP_SERIAL, 8'h00);
        chk("serial", 16'h1234, rspData);
        useSerial = 0;
        step(16'h0001);
        chk("dirup", 16'h0001, link.direction);
        step(16'hFFFF);
        chk("dirdown", 16'h0000, link.direction);
        angleIn = 16'h0000;
        step(16'h0000);
        chk("north", 16'h0001, link.northMarker);
        signalsValid = 0;
        repeat (4) @(negedge mclk);
        a = link.encA;
        angleIn = angleIn + 16'h0002;
        repeat (4) @(negedge mclk);
        chk("frozen", a, link.encA);
        chk("rsp", 16'h0006, nRsp);
        stop_test();
    end
    initial
    begin
        repeat (5000) @(negedge mclk);
        n_fail++;
        stop_test();
    end
endmodule
